// ==== oatg_regs.svh ====
`ifndef OATG_REGS_SVH
`define OATG_REGS_SVH

// =====================================================
// register addresses
`define OATG_ADDR_RST2_END      8'h1a
`define OATG_ADDR_RST3_START    8'h1b
`define OATG_ADDR_RST3_END      8'h1c
`define OATG_ADDR_PERIOD        8'h1d
`define OATG_ADDR_CONTROL       8'h1e
`define OATG_ADDR_SPARE         8'h1f
`define OATG_ADDR_PRIMARY_GAIN  8'h20
`define OATG_ADDR_AMBIENT_GAIN  8'h21

// =====================================================
// field positions
`define OATG_COUNT_MSB          15
`define OATG_TIMER_EN_BIT       8
`define OATG_AVG_MSB            7
`define OATG_SEP_GAIN_BIT       15
`define OATG_STAGE2_ON_BIT      14
`define OATG_STAGE2_GAIN_MSB    10
`define OATG_STAGE2_GAIN_LSB    8
`define OATG_CAP_MSB            7
`define OATG_CAP_LSB            3
`define OATG_RES_MSB            2
`define OATG_RES_LSB            0
`define OATG_AMB_MSB            19
`define OATG_AMB_LSB            16

// =====================================================
// reset values and limits
`define OATG_REG_RESET          24'h000000
`define OATG_AVG_LIMIT_CODE     8'h0f
`define OATG_AVG_MAX            5'h10

// =====================================================
// timing: internal timer rate derived from mclk
`define OATG_MCLK_KHZ           125000
`define OATG_TIMER_KHZ          4000

// =====================================================
// serial frame layout
`define OATG_ADDR_BITS          8
`define OATG_DATA_BITS          24
`define OATG_FRAME_BITS         6'd32

`endif

// ==== oatg_pkg.sv ====
package oatg_pkg;

    typedef enum logic [2:0] {
        OATG_SPI_IDLE = 3'b001,
        OATG_SPI_ADDR = 3'b010,
        OATG_SPI_DATA = 3'b100
    } oatg_spi_state_t;

    typedef logic [23:0] oatg_word_t;
    typedef logic [15:0] oatg_count_t;

endpackage

// ==== oatg_pulse_window.sv ====
`timescale 1ns/1ps
`default_nettype none
module oatg_pulse_window
    import oatg_pkg::*;
#(
    parameter int CW = 16
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          running,
    input  wire logic [CW-1:0] timerCount,
    input  wire logic [CW-1:0] startCount,
    input  wire logic [CW-1:0] endCount,
    output logic               pulse
);

    logic pulse_ff;

    // =====================================================
    // window compare
    // registered so the pulse is glitch free; lags the count by one mclk
    always_ff @(posedge mclk) begin
        if (rst) begin
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= running && (timerCount >= startCount) && (timerCount < endCount);
        end
    end

    assign pulse = pulse_ff;

endmodule
`default_nettype wire

// ==== oatg_timing_gain_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "oatg_regs.svh"
module oatg_timing_gain_regs
    import oatg_pkg::*;
#(
    parameter int CW = 16
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          spiSclk,
    input  wire logic          spiSteN,
    input  wire logic          spiSdi,
    output logic               spiSdo,
    output logic               spiSdoOeN,
    input  wire logic          spiReadMode,
    input  wire logic [CW-1:0] adcReset2StartCount,
    output logic               adcReset2Pulse,
    output logic               adcReset3Pulse,
    output logic               periodStart,
    output logic               timerRunning,
    output logic [CW-1:0]      timerCount,
    output logic [4:0]         averageCount,
    output logic               led1SecondStageOn,
    output logic [2:0]         led1SecondStageGain,
    output logic [4:0]         led1FeedbackCapCode,
    output logic [2:0]         led1FeedbackResCode,
    output logic               led2SecondStageOn,
    output logic [2:0]         led2SecondStageGain,
    output logic [4:0]         led2FeedbackCapCode,
    output logic [2:0]         led2FeedbackResCode,
    output logic               filterCornerSelect,
    output logic [3:0]         ambientCancelCurrent
);

    localparam int ACC_W = 17;
    localparam logic [ACC_W-1:0] TICK_STEP = ACC_W'(`OATG_TIMER_KHZ);
    localparam logic [ACC_W-1:0] TICK_MOD  = ACC_W'(`OATG_MCLK_KHZ);

    oatg_spi_state_t spiState_ff;
    oatg_spi_state_t nxt_spiState;
    logic            sclkPrev_ff;
    logic [5:0]      bitCount_ff;
    logic [7:0]      addr_ff;
    oatg_word_t      shift_ff;
    oatg_word_t      readShadow_ff;
    logic            spiSdo_ff;
    logic            spiSdoOeN_ff;
    logic            sclkRise;
    logic            sclkFall;
    logic            writeStrobe;
    oatg_word_t      writeData;
    oatg_word_t      readData;

    oatg_word_t      rst2End_ff;
    oatg_word_t      rst3Start_ff;
    oatg_word_t      rst3End_ff;
    oatg_word_t      period_ff;
    oatg_word_t      control_ff;
    oatg_word_t      primaryGain_ff;
    oatg_word_t      ambientGain_ff;

    logic [ACC_W-1:0] tickAcc_ff;
    logic             tick_ff;
    logic [CW-1:0]    count_ff;
    logic             periodStart_ff;
    logic [CW:0]      countNext;
    logic             timerEnable;
    logic [CW-1:0]    periodCount;
    logic [7:0]       avgField;
    logic [4:0]       avgCount_ff;

    logic             led1On_ff;
    logic [2:0]       led1Gain_ff;
    logic [4:0]       led1Cap_ff;
    logic [2:0]       led1Res_ff;
    logic             led2On_ff;
    logic [2:0]       led2Gain_ff;
    logic [4:0]       led2Cap_ff;
    logic [2:0]       led2Res_ff;
    logic             filterSel_ff;
    logic [3:0]       ambCurrent_ff;
    logic             sepGain;

    // =====================================================
    // serial slave: sclk sampled on mclk, edges from a registered copy
    assign sclkRise = spiSclk && !sclkPrev_ff;
    assign sclkFall = !spiSclk && sclkPrev_ff;

    always_ff @(posedge mclk) begin
        if (rst) begin
            sclkPrev_ff <= 1'b0;
        end else begin
            sclkPrev_ff <= spiSclk;
        end
    end

    always_comb begin
        nxt_spiState = spiState_ff;
        case (spiState_ff)
            OATG_SPI_IDLE: begin
                if (!spiSteN) begin
                    nxt_spiState = OATG_SPI_ADDR;
                end
            end
            OATG_SPI_ADDR: begin
                if (spiSteN) begin
                    nxt_spiState = OATG_SPI_IDLE;
                end else if (sclkRise && bitCount_ff == 6'(`OATG_ADDR_BITS - 1)) begin
                    nxt_spiState = OATG_SPI_DATA;
                end
            end
            OATG_SPI_DATA: begin
                if (spiSteN || (sclkRise && bitCount_ff == `OATG_FRAME_BITS - 6'd1)) begin
                    nxt_spiState = OATG_SPI_IDLE;
                end
            end
            default: begin
                nxt_spiState = OATG_SPI_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            spiState_ff <= OATG_SPI_IDLE;
        end else begin
            spiState_ff <= nxt_spiState;
        end
    end

    // a frame cut short by a rising select is dropped without a write
    always_ff @(posedge mclk) begin
        if (rst) begin
            bitCount_ff <= 6'h00;
            addr_ff     <= 8'h00;
            shift_ff    <= `OATG_REG_RESET;
        end else if (spiState_ff == OATG_SPI_IDLE || spiSteN) begin
            bitCount_ff <= 6'h00;
        end else if (sclkRise) begin
            bitCount_ff <= bitCount_ff + 6'h01;
            if (spiState_ff == OATG_SPI_ADDR) begin
                addr_ff <= {addr_ff[6:0], spiSdi};
            end else begin
                shift_ff <= {shift_ff[22:0], spiSdi};
            end
        end
    end

    assign writeStrobe = (spiState_ff == OATG_SPI_DATA) && !spiSteN && sclkRise
                         && (bitCount_ff == `OATG_FRAME_BITS - 6'd1) && !spiReadMode;
    assign writeData   = {shift_ff[22:0], spiSdi};

    // read shadow captured once the address is complete, shifted out on falling sclk
    always_ff @(posedge mclk) begin
        if (rst) begin
            readShadow_ff <= `OATG_REG_RESET;
            spiSdo_ff     <= 1'b0;
        end else if (spiState_ff == OATG_SPI_ADDR && nxt_spiState == OATG_SPI_DATA) begin
            readShadow_ff <= readData;
        end else if (spiState_ff == OATG_SPI_DATA && sclkFall) begin
            spiSdo_ff     <= readShadow_ff[23];
            readShadow_ff <= {readShadow_ff[22:0], 1'b0};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            spiSdoOeN_ff <= 1'b1;
        end else begin
            spiSdoOeN_ff <= !(spiReadMode && !spiSteN && spiState_ff == OATG_SPI_DATA);
        end
    end

    assign spiSdo    = spiSdo_ff;
    assign spiSdoOeN = spiSdoOeN_ff;

    // =====================================================
    // register file; the address is taken from the shifter one bit early
    always_comb begin
        case ({addr_ff[6:0], spiSdi})
            `OATG_ADDR_RST2_END:     readData = rst2End_ff;
            `OATG_ADDR_RST3_START:   readData = rst3Start_ff;
            `OATG_ADDR_RST3_END:     readData = rst3End_ff;
            `OATG_ADDR_PERIOD:       readData = period_ff;
            `OATG_ADDR_CONTROL:      readData = control_ff;
            `OATG_ADDR_PRIMARY_GAIN: readData = primaryGain_ff;
            `OATG_ADDR_AMBIENT_GAIN: readData = ambientGain_ff;
            default:                 readData = `OATG_REG_RESET;
        endcase
    end

    // stored bits are kept as written; upper bits the host must zero are not
    // used by the logic, so a stray write there has no effect
    always_ff @(posedge mclk) begin
        if (rst) begin
            rst2End_ff     <= `OATG_REG_RESET;
            rst3Start_ff   <= `OATG_REG_RESET;
            rst3End_ff     <= `OATG_REG_RESET;
            period_ff      <= `OATG_REG_RESET;
            control_ff     <= `OATG_REG_RESET;
            primaryGain_ff <= `OATG_REG_RESET;
            ambientGain_ff <= `OATG_REG_RESET;
        end else if (writeStrobe) begin
            case (addr_ff)
                `OATG_ADDR_RST2_END:     rst2End_ff     <= writeData;
                `OATG_ADDR_RST3_START:   rst3Start_ff   <= writeData;
                `OATG_ADDR_RST3_END:     rst3End_ff     <= writeData;
                `OATG_ADDR_PERIOD:       period_ff      <= writeData;
                `OATG_ADDR_CONTROL:      control_ff     <= writeData;
                `OATG_ADDR_PRIMARY_GAIN: primaryGain_ff <= writeData;
                `OATG_ADDR_AMBIENT_GAIN: ambientGain_ff <= writeData;
                default: begin
                end
            endcase
        end
    end

    // =====================================================
    // 4-MHz tick from mclk by fractional accumulation; jitter of one mclk
    // on each tick is traded for not needing a second clock
    assign timerEnable = control_ff[`OATG_TIMER_EN_BIT];
    assign periodCount = period_ff[`OATG_COUNT_MSB:0];

    always_ff @(posedge mclk) begin
        if (rst || !timerEnable) begin
            tickAcc_ff <= '0;
            tick_ff    <= 1'b0;
        end else if (tickAcc_ff + TICK_STEP >= TICK_MOD) begin
            tickAcc_ff <= tickAcc_ff + TICK_STEP - TICK_MOD;
            tick_ff    <= 1'b1;
        end else begin
            tickAcc_ff <= tickAcc_ff + TICK_STEP;
            tick_ff    <= 1'b0;
        end
    end

    // =====================================================
    // period counter runs 0..period-1, so one period is exactly periodCount ticks;
    // period below 800 is the host's fault, still wraps; one spare bit avoids overflow
    assign countNext = {1'b0, count_ff} + {{CW{1'b0}}, 1'b1};

    always_ff @(posedge mclk) begin
        if (rst || !timerEnable) begin
            count_ff       <= '0;
            periodStart_ff <= 1'b0;
        end else if (tick_ff) begin
            if (countNext >= {1'b0, periodCount}) begin
                count_ff       <= '0;
                periodStart_ff <= 1'b1;
            end else begin
                count_ff       <= countNext[CW-1:0];
                periodStart_ff <= 1'b0;
            end
        end else begin
            periodStart_ff <= 1'b0;
        end
    end

    assign periodStart  = periodStart_ff;
    assign timerRunning = timerEnable;
    assign timerCount   = count_ff;

    // =====================================================
    // adc reset windows, measured against the period count
    oatg_pulse_window #(
        .CW (CW)
    ) u_rst2 (
        .mclk       (mclk),
        .rst        (rst),
        .running    (timerEnable),
        .timerCount (count_ff),
        .startCount (adcReset2StartCount),
        .endCount   (rst2End_ff[`OATG_COUNT_MSB:0]),
        .pulse      (adcReset2Pulse)
    );

    oatg_pulse_window #(
        .CW (CW)
    ) u_rst3 (
        .mclk       (mclk),
        .rst        (rst),
        .running    (timerEnable),
        .timerCount (count_ff),
        .startCount (rst3Start_ff[`OATG_COUNT_MSB:0]),
        .endCount   (rst3End_ff[`OATG_COUNT_MSB:0]),
        .pulse      (adcReset3Pulse)
    );

    // =====================================================
    // averaging count
    assign avgField = control_ff[`OATG_AVG_MSB:0];

    always_ff @(posedge mclk) begin
        if (rst) begin
            avgCount_ff <= 5'h01;
        end else if (avgField >= `OATG_AVG_LIMIT_CODE) begin
            avgCount_ff <= `OATG_AVG_MAX;
        end else begin
            avgCount_ff <= avgField[4:0] + 5'h01;
        end
    end

    assign averageCount = avgCount_ff;

    // =====================================================
    // amplifier settings per phase
    assign sepGain = primaryGain_ff[`OATG_SEP_GAIN_BIT];

    always_ff @(posedge mclk) begin
        if (rst) begin
            led1On_ff   <= 1'b0;
            led1Gain_ff <= 3'h0;
            led1Cap_ff  <= 5'h00;
            led1Res_ff  <= 3'h0;
        end else if (sepGain) begin
            led1On_ff   <= primaryGain_ff[`OATG_STAGE2_ON_BIT];
            led1Gain_ff <= primaryGain_ff[`OATG_STAGE2_GAIN_MSB:`OATG_STAGE2_GAIN_LSB];
            led1Cap_ff  <= primaryGain_ff[`OATG_CAP_MSB:`OATG_CAP_LSB];
            led1Res_ff  <= primaryGain_ff[`OATG_RES_MSB:`OATG_RES_LSB];
        end else begin
            led1On_ff   <= ambientGain_ff[`OATG_STAGE2_ON_BIT];
            led1Gain_ff <= ambientGain_ff[`OATG_STAGE2_GAIN_MSB:`OATG_STAGE2_GAIN_LSB];
            led1Cap_ff  <= ambientGain_ff[`OATG_CAP_MSB:`OATG_CAP_LSB];
            led1Res_ff  <= ambientGain_ff[`OATG_RES_MSB:`OATG_RES_LSB];
        end
    end

    // bits 13:11 and 23:20 are ignored here
    always_ff @(posedge mclk) begin
        if (rst) begin
            led2On_ff     <= 1'b0;
            led2Gain_ff   <= 3'h0;
            led2Cap_ff    <= 5'h00;
            led2Res_ff    <= 3'h0;
            filterSel_ff  <= 1'b0;
            ambCurrent_ff <= 4'h0;
        end else begin
            led2On_ff     <= ambientGain_ff[`OATG_STAGE2_ON_BIT];
            led2Gain_ff   <= ambientGain_ff[`OATG_STAGE2_GAIN_MSB:`OATG_STAGE2_GAIN_LSB];
            led2Cap_ff    <= ambientGain_ff[`OATG_CAP_MSB:`OATG_CAP_LSB];
            led2Res_ff    <= ambientGain_ff[`OATG_RES_MSB:`OATG_RES_LSB];
            filterSel_ff  <= ambientGain_ff[`OATG_SEP_GAIN_BIT];
            ambCurrent_ff <= ambientGain_ff[`OATG_AMB_MSB:`OATG_AMB_LSB];
        end
    end

    assign led1SecondStageOn    = led1On_ff;
    assign led1SecondStageGain  = led1Gain_ff;
    assign led1FeedbackCapCode  = led1Cap_ff;
    assign led1FeedbackResCode  = led1Res_ff;
    assign led2SecondStageOn    = led2On_ff;
    assign led2SecondStageGain  = led2Gain_ff;
    assign led2FeedbackCapCode  = led2Cap_ff;
    assign led2FeedbackResCode  = led2Res_ff;
    assign filterCornerSelect   = filterSel_ff;
    assign ambientCancelCurrent = ambCurrent_ff;

endmodule
`default_nettype wire

// ==== oatg_timing_gain_regs_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module oatg_timing_gain_regs_checker
    import oatg_pkg::*;
#(
    parameter int CW = 16
) (
    input wire logic          mclk,
    input wire logic          rst,
    input wire logic          spiSdoOeN,
    input wire logic [CW-1:0] adcReset2StartCount,
    input wire logic          adcReset2Pulse,
    input wire logic          adcReset3Pulse,
    input wire logic          periodStart,
    input wire logic          timerRunning,
    input wire logic [CW-1:0] timerCount,
    input wire logic [4:0]    averageCount,
    input wire logic          led1SecondStageOn,
    input wire logic          led2SecondStageOn,
    input wire logic [3:0]    ambientCancelCurrent
);
// ======================================
// helper: cycles since the count last moved
logic [CW-1:0] prevCnt_ff;
logic [5:0]    gapCnt_ff;
always_ff @(posedge mclk) begin
    prevCnt_ff <= timerCount;
end
always_ff @(posedge mclk) begin
    if (rst || !timerRunning || timerCount != prevCnt_ff) begin
        gapCnt_ff <= 6'h00;
    end else if (gapCnt_ff != 6'h3f) begin
        gapCnt_ff <= gapCnt_ff + 6'h01;
    end
end
// ======================================
// assertions
default clocking @(posedge mclk); endclocking
default disable iff (rst);
AST_RESET_QUIET: assert property ($fell(rst) |-> !periodStart && !adcReset3Pulse
    && timerCount == '0 && averageCount == 5'h01 && !led1SecondStageOn
    && !led2SecondStageOn && ambientCancelCurrent == 4'h0)
    else $error("outputs not at reset state after reset");
AST_AVG_RANGE: assert property (averageCount >= 5'h01 && averageCount <= 5'h10)
    else $error("average count outside 1..16");
AST_TIMER_OFF: assert property (!timerRunning [*2] |-> timerCount == '0
    && !adcReset3Pulse && !adcReset2Pulse && !periodStart)
    else $error("timer activity while disabled");
AST_WRAP_ZERO: assert property (periodStart |-> timerCount == '0 && $past(timerRunning))
    else $error("period start without count at zero");
AST_COUNT_STEP: assert property (timerRunning && $past(timerRunning) |->
    $stable(timerCount) || timerCount == $past(timerCount) + 16'h0001 || timerCount == '0)
    else $error("period count jumped");
// steps out of and into zero are exempt: the first step after enable is timed from the enable, not from a tick
AST_TICK_GAP: assert property (timerRunning && timerCount != prevCnt_ff
    && prevCnt_ff != '0 && timerCount != '0 |-> gapCnt_ff inside {6'h1e, 6'h1f})
    else $error("count tick spacing not 31 or 32 cycles");
AST_RST2_RISE: assert property ($rose(adcReset2Pulse) |->
    $past(timerCount) == adcReset2StartCount)
    else $error("reset two window opened at wrong count");
AST_RST2_INSIDE: assert property (adcReset2Pulse |->
    $past(timerCount) >= adcReset2StartCount)
    else $error("reset two window high before its start");
cover property (periodStart);
cover property ($rose(adcReset3Pulse));
cover property (averageCount == 5'h10);
cover property (!spiSdoOeN);
endmodule

bind oatg_timing_gain_regs oatg_timing_gain_regs_checker #(.CW(CW)) u_chk (
    .mclk                 (mclk),
    .rst                  (rst),
    .spiSdoOeN            (spiSdoOeN),
    .adcReset2StartCount  (adcReset2StartCount),
    .adcReset2Pulse       (adcReset2Pulse),
    .adcReset3Pulse       (adcReset3Pulse),
    .periodStart          (periodStart),
    .timerRunning         (timerRunning),
    .timerCount           (timerCount),
    .averageCount         (averageCount),
    .led1SecondStageOn    (led1SecondStageOn),
    .led2SecondStageOn    (led2SecondStageOn),
    .ambientCancelCurrent (ambientCancelCurrent)
);
`default_nettype wire

// ==== oatg_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module oatg_host_model
    import oatg_pkg::*;
(
    input  wire logic mclk,
    output var logic  spiSclk,
    output var logic  spiSteN,
    output var logic  spiSdi,
    output var logic  spiReadMode,
    input  wire logic spiSdo,
    input  wire logic spiSdoOeN
);
// ======================================
// released sdo line shows no stale value
logic lastSdo;
logic sdoWire;
initial begin
    lastSdo = 1'b0;
    spiSclk = 1'b0;
    spiSteN = 1'b1;
    spiSdi = 1'b0;
    spiReadMode = 1'b0;
end
always @(posedge mclk) if (!spiSdoOeN) lastSdo <= spiSdo;
assign sdoWire = spiSdoOeN ? ~lastSdo : spiSdo;
// ======================================
// one frame: 8 address bits then 24 data bits, msb first; nbits < 32 aborts
task automatic frame(input logic [7:0] a, input logic [23:0] wd, input logic rd,
                     input int nbits, output logic [23:0] rdat);
    logic [31:0] sh;
    case (a)
        8'h1a, 8'h1b, 8'h1c, 8'h1d: wd[23:16] = 8'h00;
        8'h1e: wd[23:9] = 15'h0000;
        8'h1f: wd = 24'h000000;
        8'h20: {wd[23:16], wd[13:11]} = 11'h000;
        8'h21: wd[23:20] = 4'h0;
        default: ;
    endcase
    sh = {a, wd};
    rdat = 24'h000000;
    @(negedge mclk);
    spiReadMode = rd;
    spiSteN = 1'b0;
    repeat (2) @(negedge mclk);
    for (int i = 0; i < nbits; i++) begin
        spiSdi = sh[31 - i];
        repeat (3) @(negedge mclk);
        if (i >= 8) rdat = {rdat[22:0], sdoWire};
        spiSclk = 1'b1;
        repeat (2) @(negedge mclk);
        spiSclk = 1'b0;
    end
    repeat (2) @(negedge mclk);
    spiSteN = 1'b1;
    spiReadMode = 1'b0;
    repeat (2) @(negedge mclk);
endtask
endmodule
`default_nettype wire

// ==== oatg_timing_gain_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module oatg_timing_gain_regs_tb
    import oatg_pkg::*;
;
logic        mclk, rst, spiSclk, spiSteN, spiSdi, spiSdo, spiSdoOeN, spiReadMode;
logic [15:0] adcReset2StartCount, timerCount;
logic        adcReset2Pulse, adcReset3Pulse, periodStart, timerRunning, filterCornerSelect;
logic [4:0]  averageCount, led1FeedbackCapCode, led2FeedbackCapCode;
logic [2:0]  led1SecondStageGain, led1FeedbackResCode, led2SecondStageGain, led2FeedbackResCode;
logic        led1SecondStageOn, led2SecondStageOn;
logic [3:0]  ambientCancelCurrent;
logic [28:0] gainSeen;
logic [23:0] ctrl, prim, amb, v;
logic [15:0] r3, f3, r2, f2;
logic        p3, p2;
int          miscompares, totalChecks, n;
logic [55:0] rows [15] = '{
    {8'h1a, 24'h000007, 24'h000007}, {8'h1b, 24'h000002, 24'h000002},
    {8'h1c, 24'h000005, 24'h000005}, {8'h1d, 24'h000320, 24'h000320},
    {8'h1f, 24'h000000, 24'h000000}, {8'h30, 24'h123456, 24'h000000},
    {8'h1e, 24'h000000, 24'h000000}, {8'h1e, 24'h000003, 24'h000003},
    {8'h1e, 24'h00000e, 24'h00000e}, {8'h1e, 24'h00000f, 24'h00000f},
    {8'h1e, 24'h0000c8, 24'h0000c8}, {8'h21, 24'h0a447f, 24'h0a447f},
    {8'h20, 24'h000312, 24'h000312}, {8'h20, 24'h00c186, 24'h00c186},
    {8'h20, 24'h008186, 24'h008186}};
assign gainSeen = {led1SecondStageOn, led1SecondStageGain, led1FeedbackCapCode,
    led1FeedbackResCode, led2SecondStageOn, led2SecondStageGain, led2FeedbackCapCode,
    led2FeedbackResCode, filterCornerSelect, ambientCancelCurrent};
oatg_timing_gain_regs #(.CW(16)) u_oatg_timing_gain_regs (.mclk(mclk), .rst(rst),
    .spiSclk(spiSclk), .spiSteN(spiSteN), .spiSdi(spiSdi), .spiSdo(spiSdo),
    .spiSdoOeN(spiSdoOeN), .spiReadMode(spiReadMode),
    .adcReset2StartCount(adcReset2StartCount), .adcReset2Pulse(adcReset2Pulse),
    .adcReset3Pulse(adcReset3Pulse), .periodStart(periodStart),
    .timerRunning(timerRunning), .timerCount(timerCount), .averageCount(averageCount),
    .led1SecondStageOn(led1SecondStageOn), .led1SecondStageGain(led1SecondStageGain),
    .led1FeedbackCapCode(led1FeedbackCapCode), .led1FeedbackResCode(led1FeedbackResCode),
    .led2SecondStageOn(led2SecondStageOn), .led2SecondStageGain(led2SecondStageGain),
    .led2FeedbackCapCode(led2FeedbackCapCode), .led2FeedbackResCode(led2FeedbackResCode),
    .filterCornerSelect(filterCornerSelect), .ambientCancelCurrent(ambientCancelCurrent));
oatg_host_model u_oatg_host_model (.mclk(mclk), .spiSclk(spiSclk), .spiSteN(spiSteN),
    .spiSdi(spiSdi), .spiReadMode(spiReadMode), .spiSdo(spiSdo), .spiSdoOeN(spiSdoOeN));
// ======================================
// expectations and helpers
function automatic logic [4:0] expAvg(input logic [23:0] c);
    return (c[7:0] >= 8'h0f) ? 5'h10 : 5'(c[7:0] + 8'h01);
endfunction
function automatic logic [28:0] expGain(input logic [23:0] p, input logic [23:0] m);
    logic [23:0] s;
    s = p[15] ? p : m;
    return {s[14], s[10:0], m[14], m[10:0], m[15], m[19:16]};
endfunction
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
        miscompares++;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic rdChk(input logic [7:0] a, input logic [23:0] e);
    logic [23:0] rv;
    u_oatg_host_model.frame(a, 24'h000000, 1'b1, 32, rv);
    chk("readback", {8'h00, e}, {8'h00, rv});
endtask
task automatic doRow(input logic [7:0] a, input logic [23:0] d, input logic [23:0] r);
    logic [23:0] rv;
    u_oatg_host_model.frame(a, d, 1'b0, 32, rv);
    if (a == 8'h1e) ctrl = d;
    if (a == 8'h20) prim = d;
    if (a == 8'h21) amb = d;
    rdChk(a, r);
    chk("averageCount", {27'h0, expAvg(ctrl)}, {27'h0, averageCount});
    chk("gain", {3'h0, expGain(prim, amb)}, {3'h0, gainSeen});
endtask
task automatic waitStart(output int cnt);
    cnt = 0;
    do begin
        @(negedge mclk);
        cnt++;
    end while (periodStart !== 1'b1 && cnt < 26000);
endtask
task automatic results();
    $display("checks %0d miscompares %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
endtask
// window edges seen mid-cycle, once the design has settled
always @(negedge mclk) begin
    if (adcReset3Pulse !== p3) if (adcReset3Pulse) r3 = timerCount; else f3 = timerCount;
    if (adcReset2Pulse !== p2) if (adcReset2Pulse) r2 = timerCount; else f2 = timerCount;
    p3 = adcReset3Pulse;
    p2 = adcReset2Pulse;
end
initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
end
initial begin
    repeat (90000) @(posedge mclk);
    miscompares++;
    results();
end
// ======================================
// main sequence
initial begin
    rst = 1'b1;
    adcReset2StartCount = 16'h0003;
    {ctrl, prim, amb, miscompares, totalChecks, p3, p2} = '0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    for (int a = 8'h1a; a <= 8'h21; a++) rdChk(8'(a), 24'h000000);
    chk("averageCount", 32'h1, {27'h0, averageCount});
    $display("test reset values done");
    foreach (rows[i]) doRow(rows[i][55:48], rows[i][47:24], rows[i][23:0]);
    for (int k = 0; k <= 10; k++) begin
        v = 24'((k << 16) | ((k & 1) << 14) | ((k % 5) << 8) | (1 << (3 + k % 5)) | (k % 8));
        doRow(8'h21, v, v);
    end
    $display("test register table done");
    doRow(8'h1e, 24'h000103, 24'h000103);
    chk("timerRunning", 32'h1, {31'h0, timerRunning});
    waitStart(n);
    {r3, f3, r2, f2} = '1;
    waitStart(n);
    chk("period cycles", 32'd25000, n);
    chk("reset3 start", 32'h2, {16'h0, r3});
    chk("reset3 end", 32'h5, {16'h0, f3});
    chk("reset2 start", 32'h3, {16'h0, r2});
    chk("reset2 end", 32'h7, {16'h0, f2});
    doRow(8'h1e, 24'h000003, 24'h000003);
    chk("timer off", 32'h0, {15'h0, timerRunning, timerCount});
    $display("test timer done");
    u_oatg_host_model.frame(8'h1b, 24'h000099, 1'b0, 20, v);
    rdChk(8'h1b, 24'h000002);
    $display("test aborted frame done");
    @(negedge mclk);
    rst = 1'b1;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    {ctrl, prim, amb} = '0;
    rdChk(8'h21, 24'h000000);
    rdChk(8'h1e, 24'h000000);
    chk("gain", 32'h0, {3'h0, gainSeen});
    $display("test mid-run reset done");
    results();
end
endmodule
`default_nettype wire
